// file: verilog/sciss_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Break after 10/11 bits, extend adds one
// - Extend bit blocks framing and full flags
// - Active flag: valid start sets, idle clears
// - Polarity invert flips the whole receive line
// - Ninth bit above byte; data read clears full flag, not ninth bit
// - Data write sends stored ninth bit too
// - Single wire: direction bit sets pin direction
module sciss_top
    import sciss_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    output logic o_irq,
    // Serial line
    input wire logic i_rxd,
    input wire logic i_txd_pin,
    output logic o_txd,
    output logic o_txd_oe
);
    logic [7:0] ctrl1_r, baud_r, stat1_r, mask_r, rx_data_r, rd_data_r;
    logic [7:0] ctrl1_nxt, baud_nxt, stat1_nxt, mask_nxt, rx_data_nxt, rd_data_nxt;
    logic break_length_extend_r, break_length_extend_nxt, irq_r, irq_nxt, txd_oe_r, txd_oe_nxt, raf_r, raf_nxt;
    sciss_ctl3_s ctl3_r, ctl3_nxt;
    sciss_tx_e tx_st_r, tx_st_nxt;
    logic [10:0] tx_sh_r, tx_sh_nxt;
    sciss_rx_e rx_st_r, rx_st_nxt;
    logic [7:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt, low_cnt_r, low_cnt_nxt, bit_last;
    logic [3:0] tx_bit_r, tx_bit_nxt, rx_bit_r, rx_bit_nxt, low_bits_r, low_bits_nxt, brk_thr;
    logic [8:0] rx_sh_r, rx_sh_nxt, rx_word;
    logic rx_in, nine, single, rx_load, fe_ev, brk_ev, data_wr, brk_seen_r, brk_seen_nxt;
    assign nine = ctrl1_r[C1_NINE];
    assign single = ctrl1_r[C1_LOOP] & ctrl1_r[C1_RECEIVER_SOURCE_SELECT];
    assign bit_last = baud_r - 8'h01;
    assign brk_thr = BRK_BASE + {3'b000, nine} + {3'b000, break_length_extend_r};
    assign data_wr = i_wr_en && i_addr == A_DATA;
    // Receive source; inversion covers start, data, stop, break and idle
    assign rx_in = (ctrl1_r[C1_LOOP] && !ctrl1_r[C1_RECEIVER_SOURCE_SELECT] ? tx_sh_r[0]
        : single ? i_txd_pin : i_rxd) ^ ctl3_r.rx_polarity_invert;
    // Receiver next state
    always_comb
    begin
        rx_st_nxt = rx_st_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        raf_nxt = raf_r;
        low_cnt_nxt = low_cnt_r;
        low_bits_nxt = low_bits_r;
        brk_seen_nxt = brk_seen_r;
        rx_load = 1'b0;
        fe_ev = 1'b0;
        brk_ev = 1'b0;
        rx_word = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
        unique case (rx_st_r)
            RX_IDLE:
                if (ctrl1_r[C1_RXEN] && !rx_in)
                begin
                    rx_st_nxt = RX_START;
                    rx_cnt_nxt = {1'b0, baud_r[7:1]};
                end
            RX_START:
            begin
                if (rx_cnt_r != 8'h00)
                    rx_cnt_nxt = rx_cnt_r - 8'h01;
                else if (!rx_in)
                begin
                    rx_st_nxt = RX_DATA;
                    rx_cnt_nxt = bit_last;
                    rx_bit_nxt = 4'h0;
                    raf_nxt = 1'b1;
                end
                else
                    rx_st_nxt = RX_IDLE;
            end
            RX_DATA:
            begin
                if (rx_cnt_r != 8'h00)
                    rx_cnt_nxt = rx_cnt_r - 8'h01;
                else
                begin
                    rx_sh_nxt = {rx_in, rx_sh_r[8:1]};
                    rx_cnt_nxt = bit_last;
                    rx_bit_nxt = rx_bit_r + 4'h1;
                    if (rx_bit_r == (nine ? LAST_BIT9 : LAST_BIT8))
                        rx_st_nxt = RX_STOP;
                end
            end
            RX_STOP:
            begin
                if (rx_cnt_r != 8'h00)
                    rx_cnt_nxt = rx_cnt_r - 8'h01;
                else if (rx_in)
                begin
                    rx_load = !break_length_extend_r;
                    rx_st_nxt = RX_IDLE;
                end
                else
                begin
                    fe_ev = !break_length_extend_r;
                    rx_st_nxt = RX_HOLD;
                end
            end
            RX_HOLD:
                if (rx_in)
                    rx_st_nxt = RX_IDLE;
        endcase
        if (rx_st_r == RX_IDLE && rx_in)
            raf_nxt = 1'b0;
        // Low run counted apart from framing so breaks show in any state
        if (rx_in || !ctrl1_r[C1_RXEN])
        begin
            low_cnt_nxt = 8'h00;
            low_bits_nxt = 4'h0;
            brk_seen_nxt = 1'b0;
        end
        else if (!brk_seen_r)
        begin
            if (low_cnt_r == bit_last)
            begin
                low_cnt_nxt = 8'h00;
                low_bits_nxt = low_bits_r + 4'h1;
                if (low_bits_r + 4'h1 == brk_thr)
                begin
                    brk_ev = 1'b1;
                    brk_seen_nxt = 1'b1;
                end
            end
            else
                low_cnt_nxt = low_cnt_r + 8'h01;
        end
    end
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= RST_ZERO;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 9'h000;
            raf_r <= 1'b0;
            low_cnt_r <= RST_ZERO;
            low_bits_r <= 4'h0;
            brk_seen_r <= 1'b0;
        end
        else
        begin
            rx_st_r <= rx_st_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            raf_r <= raf_nxt;
            low_cnt_r <= low_cnt_nxt;
            low_bits_r <= low_bits_nxt;
            brk_seen_r <= brk_seen_nxt;
        end
    end
    // Registers, transmitter and read port
    always_comb
    begin
        logic [7:0] ev, clr;
        ev = 8'h00;
        clr = 8'h00;
        ctrl1_nxt = ctrl1_r;
        baud_nxt = baud_r;
        mask_nxt = mask_r;
        break_length_extend_nxt = break_length_extend_r;
        ctl3_nxt = ctl3_r;
        rx_data_nxt = rx_data_r;
        tx_st_nxt = tx_st_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_bit_nxt = tx_bit_r;
        tx_sh_nxt = tx_sh_r;
        rd_data_nxt = RST_ZERO;
        if (i_wr_en)
        begin
            unique case (i_addr)
                A_CTRL1: ctrl1_nxt = i_wr_data;
                A_BAUD: baud_nxt = i_wr_data;
                A_STAT1: clr = i_wr_data;
                A_MASK: mask_nxt = i_wr_data;
                A_STAT2: break_length_extend_nxt = i_wr_data[S2_BREAK_LENGTH_EXTEND];
                A_CTRL3:
                begin
                    // Ninth receive bit keeps its value on writes
                    ctl3_nxt.tx_ninth_bit = i_wr_data[6];
                    ctl3_nxt.single_wire_tx_direction = i_wr_data[5];
                    ctl3_nxt.rx_polarity_invert = i_wr_data[4];
                end
                default: ;
            endcase
        end
        if (i_rd_en)
        begin
            unique case (i_addr)
                A_CTRL1: rd_data_nxt = ctrl1_r;
                A_BAUD: rd_data_nxt = baud_r;
                A_STAT1: rd_data_nxt = stat1_r;
                A_MASK: rd_data_nxt = mask_r;
                A_STAT2: rd_data_nxt = {6'h00, break_length_extend_r, raf_r};
                A_CTRL3: rd_data_nxt = {ctl3_r[7:4], 4'h0};
                A_DATA:
                begin
                    rd_data_nxt = rx_data_r;
                    clr[S1_RXFULL] = 1'b1;
                end
                default: rd_data_nxt = RST_ZERO;
            endcase
        end
        if (rx_load)
        begin
            rx_data_nxt = rx_word[7:0];
            ctl3_nxt.rx_ninth_bit = nine & rx_word[8];
            ev[S1_RXFULL] = 1'b1;
        end
        ev[S1_FERR] = fe_ev;
        ev[S1_BRK] = brk_ev;
        unique case (tx_st_r)
            TX_IDLE:
            begin
                // A write while busy is dropped; software waits for done
                if (data_wr && ctrl1_r[C1_TXEN])
                begin
                    tx_sh_nxt = nine ? {1'b1, ctl3_r.tx_ninth_bit, i_wr_data, 1'b0}
                                     : {2'b11, i_wr_data, 1'b0};
                    tx_st_nxt = TX_SHIFT;
                    tx_cnt_nxt = bit_last;
                    tx_bit_nxt = 4'h0;
                end
            end
            TX_SHIFT:
            begin
                if (tx_cnt_r != 8'h00)
                    tx_cnt_nxt = tx_cnt_r - 8'h01;
                else
                begin
                    tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
                    tx_cnt_nxt = bit_last;
                    tx_bit_nxt = tx_bit_r + 4'h1;
                    if (tx_bit_r + 4'h1 == (nine ? FRAME9 : FRAME8))
                    begin
                        tx_st_nxt = TX_IDLE;
                        ev[S1_TXDONE] = 1'b1;
                    end
                end
            end
        endcase
        stat1_nxt = (stat1_r & ~clr) | ev;
        irq_nxt = |(stat1_nxt & mask_nxt);
        txd_oe_nxt = single ? ctl3_nxt.single_wire_tx_direction : 1'b1;
    end
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl1_r <= RST_CTRL1;
            baud_r <= RST_BAUD;
            stat1_r <= RST_ZERO;
            mask_r <= RST_ZERO;
            break_length_extend_r <= 1'b0;
            ctl3_r <= RST_ZERO;
            rx_data_r <= RST_ZERO;
            rd_data_r <= RST_ZERO;
            irq_r <= 1'b0;
            txd_oe_r <= 1'b1;
            tx_st_r <= TX_IDLE;
            tx_cnt_r <= RST_ZERO;
            tx_bit_r <= 4'h0;
            tx_sh_r <= TX_IDLE_WORD;
        end
        else
        begin
            ctrl1_r <= ctrl1_nxt;
            baud_r <= baud_nxt;
            stat1_r <= stat1_nxt;
            mask_r <= mask_nxt;
            break_length_extend_r <= break_length_extend_nxt;
            ctl3_r <= ctl3_nxt;
            rx_data_r <= rx_data_nxt;
            rd_data_r <= rd_data_nxt;
            irq_r <= irq_nxt;
            txd_oe_r <= txd_oe_nxt;
            tx_st_r <= tx_st_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt;
        end
    end
    assign o_rd_data = rd_data_r;
    assign o_irq = irq_r;
    assign o_txd = tx_sh_r[0];
    assign o_txd_oe = txd_oe_r;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_start_ok;
        rx_st_r == RX_START && rx_cnt_r == 8'h00 && !rx_in;
    endsequence
    sequence s_ctl3_write;
        i_wr_en && i_addr == A_CTRL3 && !rx_load;
    endsequence
    // Thresholds written from the base count, not from brk_thr, so a bad sum shows
    brk_thresh_a: assert property (brk_ev && !break_length_extend_r
        |-> low_bits_r == BRK_BASE - 4'h1 + {3'b000, nine})
        else $error("break flagged at wrong length");
    brk_lbk_a: assert property (brk_ev && break_length_extend_r
        |-> low_bits_r == BRK_BASE + {3'b000, nine})
        else $error("extended break length wrong");
    lbk_block_a: assert property (break_length_extend_r
        |=> !$rose(stat1_r[S1_RXFULL]) && !$rose(stat1_r[S1_FERR]))
        else $error("flag set while extend bit on");
    raf_set_a: assert property (s_start_ok |=> raf_r)
        else $error("active flag missed start");
    raf_clr_a: assert property (rx_st_r == RX_IDLE && rx_in |=> !raf_r)
        else $error("active flag not cleared at idle");
    r8_load_a: assert property (rx_load && nine |=> ctl3_r.rx_ninth_bit == $past(rx_sh_r[8]))
        else $error("ninth receive bit not captured");
    tx_nine_a: assert property (tx_st_r == TX_IDLE && data_wr && ctrl1_r[C1_TXEN] && nine
        |=> tx_sh_r[9] == $past(ctl3_r.tx_ninth_bit) && tx_sh_r[8:1] == $past(i_wr_data))
        else $error("ninth transmit bit not loaded");
    single_wire_tx_direction_a: assert property (single ##1 single |-> o_txd_oe == ctl3_r.single_wire_tx_direction)
        else $error("single wire direction wrong");
    ro_bits_a: assert property (s_ctl3_write |=> $stable(ctl3_r.rx_ninth_bit))
        else $error("read-only ninth bit changed");
endmodule : sciss_top

// file: verilog/sciss_pkg.sv
package sciss_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] A_CTRL1 = 3'h0;
    localparam logic [2:0] A_BAUD = 3'h1;
    localparam logic [2:0] A_STAT1 = 3'h2;
    localparam logic [2:0] A_MASK = 3'h3;
    localparam logic [2:0] A_STAT2 = 3'h4;
    localparam logic [2:0] A_CTRL3 = 3'h5;
    localparam logic [2:0] A_DATA = 3'h6;
    // Control one bit positions
    localparam int C1_NINE = 0;
    localparam int C1_LOOP = 1;
    localparam int C1_RECEIVER_SOURCE_SELECT = 2;
    localparam int C1_RXEN = 3;
    localparam int C1_TXEN = 4;
    // Status one event positions
    localparam int S1_RXFULL = 0;
    localparam int S1_FERR = 1;
    localparam int S1_BRK = 2;
    localparam int S1_TXDONE = 3;
    // Status two positions
    localparam int S2_BREAK_LENGTH_EXTEND = 1;
    localparam int S2_RAF = 0;
    // Reset values
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h57;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [10:0] TX_IDLE_WORD = 11'h7ff;
    // Break threshold, last data bit indices and frame lengths in bit times
    localparam logic [3:0] BRK_BASE = 4'ha;
    localparam logic [3:0] LAST_BIT8 = 4'h7;
    localparam logic [3:0] LAST_BIT9 = 4'h8;
    localparam logic [3:0] FRAME8 = 4'ha;
    localparam logic [3:0] FRAME9 = 4'hb;

    typedef struct packed {
        logic rx_ninth_bit;
        logic tx_ninth_bit;
        logic single_wire_tx_direction;
        logic rx_polarity_invert;
        logic [3:0] unused;
    } sciss_ctl3_s;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HOLD} sciss_rx_e;
    typedef enum logic {TX_IDLE, TX_SHIFT} sciss_tx_e;
endpackage : sciss_pkg

// file: verification/sciss_node.sv
`timescale 1ns/1ns
module sciss_node
(
    // Clock
    input wire logic i_clk,
    // Serial line
    input wire logic i_tx,
    output logic o_line
);
    initial o_line = 1'b1;

    // Start, data LSB first, stop; inv flips every element
    task automatic send_frame(input logic [8:0] d, input logic nine, input logic inv,
        input int bt);
        logic [10:0] w;
        w = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
        @(posedge i_clk);
        for (int i = 0; i < (nine ? 11 : 10); i++)
        begin
            o_line <= w[i] ^ inv;
            repeat (bt) @(posedge i_clk);
        end
    endtask : send_frame

    task automatic hold(input logic lvl, input int clks);
        @(posedge i_clk);
        o_line <= lvl;
        repeat (clks) @(posedge i_clk);
    endtask : hold

    // Samples mid-bit; stop bit left to run out
    task automatic get_frame(output logic [8:0] d, input logic nine, input int bt);
        d = 9'h000;
        do @(posedge i_clk); while (i_tx !== 1'b0);
        repeat (bt / 2) @(posedge i_clk);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
            repeat (bt) @(posedge i_clk);
            d[i] = i_tx;
        end
    endtask : get_frame
endmodule : sciss_node

// file: verification/tb_sciss_top.sv
`timescale 1ns/1ns
module tb_sciss_top;
    import sciss_pkg::*;
    localparam int B = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic irq, txd, txd_oe, line, pin;
    int fail_count = 0;
    int tests_run = 0;

    // Pin level seen by both ends in single-wire mode
    assign pin = txd_oe ? txd : line;
    always #50 clk = ~clk;

    sciss_top u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rdata), .o_irq(irq), .i_rxd(line),
        .i_txd_pin(pin), .o_txd(txd), .o_txd_oe(txd_oe));
    sciss_node u_node (.i_clk(clk), .i_tx(pin), .o_line(line));

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string m);
        logic [7:0] d;
        rd(a, d);
        chk({1'b0, d}, {1'b0, e}, m);
    endtask : rdchk

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic t_reset;
        rdchk(A_STAT2, 8'h00, "stat2");
        rdchk(A_CTRL3, 8'h00, "ctrl3");
        chk({8'h00, txd_oe}, 9'h001, "oe");
        wr(A_STAT2, 8'h01);
        rdchk(A_STAT2, 8'h00, "raf ro");
        wr(3'h7, 8'hff);
        rdchk(3'h7, 8'h00, "unmapped");
        wr(A_BAUD, 8'h08);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_rx9;
        logic [7:0] d;
        wr(A_CTRL1, 8'h19);
        fork
            u_node.send_frame(9'h1a5, 1'b1, 1'b0, B);
            begin
                repeat (3 * B) @(posedge clk);
                rd(A_STAT2, d);
                chk({8'h00, d[S2_RAF]}, 9'h001, "raf busy");
            end
        join
        repeat (2 * B) @(posedge clk);
        rdchk(A_STAT2, 8'h00, "raf idle");
        rdchk(A_STAT1, 8'h01, "rx full");
        wr(A_CTRL3, 8'h00);
        rdchk(A_CTRL3, 8'h80, "ninth");
        rdchk(A_DATA, 8'ha5, "rx byte");
        rdchk(A_STAT1, 8'h00, "full clr");
        $display("t_rx9 done");
    endtask : t_rx9

    task automatic t_inv;
        // Receiver off while the idle level flips, or it would see a start
        wr(A_CTRL1, 8'h10);
        u_node.hold(1'b0, 2);
        wr(A_CTRL3, 8'h10);
        wr(A_CTRL1, 8'h18);
        u_node.send_frame(9'h03c, 1'b0, 1'b1, B);
        repeat (2 * B) @(posedge clk);
        rdchk(A_STAT1, 8'h01, "inv full");
        rdchk(A_DATA, 8'h3c, "inv byte");
        wr(A_CTRL1, 8'h10);
        u_node.hold(1'b1, 2);
        wr(A_CTRL3, 8'h00);
        $display("t_inv done");
    endtask : t_inv

    task automatic t_brk;
        logic [7:0] d;
        logic nine, ext, lng;
        int thr;
        for (int k = 0; k < 8; k++)
        begin
            {lng, ext, nine} = k[2:0];
            thr = 10 + nine + ext;
            wr(A_CTRL1, {7'h0c, nine});
            wr(A_STAT2, {6'h00, ext, 1'b0});
            wr(A_STAT1, 8'h0f);
            u_node.hold(1'b0, thr * B + (lng ? B / 2 : -B / 2));
            u_node.hold(1'b1, 3 * B);
            rd(A_STAT1, d);
            chk({8'h00, d[S1_BRK]}, {8'h00, lng}, "break");
            if (ext)
            begin
                chk({7'h00, d[S1_FERR], d[S1_RXFULL]}, 9'h000, "inhibit");
            end
            else
            begin
                // Long low run ends with a low stop bit, short one with a high stop
                chk({7'h00, d[S1_FERR], d[S1_RXFULL]}, {7'h00, lng, !lng}, "stop");
            end
        end
        wr(A_STAT2, 8'h00);
        wr(A_STAT1, 8'h0f);
        $display("t_brk done");
    endtask : t_brk

    task automatic t_tx9;
        logic [8:0] f;
        wr(A_CTRL1, 8'h19);
        wr(A_CTRL3, 8'h40);
        wr(A_STAT1, 8'h0f);
        // Second byte relies on the stored ninth bit
        for (int j = 0; j < 2; j++)
        begin
            fork
                u_node.get_frame(f, 1'b1, B);
                wr(A_DATA, j ? 8'h31 : 8'h96);
            join
            chk(f, j ? 9'h131 : 9'h196, "tx frame");
            settle(2 * B);
        end
        chk({8'h00, irq}, 9'h000, "irq masked");
        wr(A_MASK, 8'h08);
        settle(3);
        chk({8'h00, irq}, 9'h001, "irq set");
        wr(A_STAT1, 8'h08);
        settle(3);
        chk({8'h00, irq}, 9'h000, "irq clr");
        wr(A_MASK, 8'h00);
        $display("t_tx9 done");
    endtask : t_tx9

    task automatic t_dir;
        wr(A_CTRL1, 8'h1e);
        wr(A_CTRL3, 8'h00);
        settle(3);
        chk({8'h00, txd_oe}, 9'h000, "pin input");
        u_node.send_frame(9'h05a, 1'b0, 1'b0, B);
        repeat (2 * B) @(posedge clk);
        rdchk(A_DATA, 8'h5a, "sw byte");
        wr(A_CTRL3, 8'h20);
        settle(3);
        chk({8'h00, txd_oe}, 9'h001, "pin output");
        // Internal loop: receiver hears its own transmitter
        wr(A_CTRL1, 8'h1a);
        wr(A_DATA, 8'h6c);
        settle(12 * B);
        rdchk(A_DATA, 8'h6c, "loop byte");
        $display("t_dir done");
    endtask : t_dir

    task automatic finish_test;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (30000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_rx9();
        t_inv();
        t_brk();
        t_tx9();
        t_dir();
        finish_test();
    end
endmodule : tb_sciss_top
